// file: core/mic_irq_regs.vh
/*
 * Register indices, field positions, vectors and timing figures of the
 * interrupt controller. Assumes it is included by bare name.
 */
`ifndef MIC_IRQ_REGS_VH
`define MIC_IRQ_REGS_VH

// register indices; the byte address is four times the index
`define MIC_IDX_GLOBAL_EN 8'h20
`define MIC_IDX_EP_EN 8'h21
`define MIC_IDX_STATUS 8'hff

// global enable fields
`define MIC_GEN_BUSRST 0
`define MIC_GEN_T128 1
`define MIC_GEN_T1024 2
`define MIC_GEN_SINK 4
`define MIC_GEN_GPIO 5
`define MIC_GEN_WMASK 8'h37
`define MIC_EP_WMASK 8'h07
`define MIC_EN_RESET 8'h00

// status fields
`define MIC_ST_GIE 2
`define MIC_ST_BUSRST 5
`define MIC_ST_PEND 7

// vector numbers; the vector address is twice the number
`define MIC_VEC_RESET 4'h0
`define MIC_VEC_BUSRST 4'h1
`define MIC_VEC_T128 4'h2
`define MIC_VEC_T1024 4'h3
`define MIC_VEC_EP0 4'h4
`define MIC_VEC_SINK 4'ha
`define MIC_VEC_GPIO 4'hb
`define MIC_VEC_LAST 4'hc

// timing
`define MIC_CLK_PERIOD_NS 10
`define MIC_SE0_TIME_NS 8000
`define MIC_CALL_CYCLES 4'ha
`define MIC_JUMP_CYCLES 4'h5

`endif

// file: core/mic_irq_ctrl.v
/*
 * Interrupt controller: request latches, enable registers, priority pick
 * and acknowledge sequencer, with a classic Wishbone register slave.
 * Assumes the processor core runs on core_clk_in, marks the last cycle
 * of each instruction, and performs the call and return stack work.
 */
// Chosen here: the Wishbone register port.
`include "mic_irq_regs.vh"
`default_nettype none

// How it works
// RQ1 - a one in an enable bit lets that source request; zero blocks it
// RQ2 - reset clears the global and endpoint enable registers
// RQ3 - pending latches sampled only in an instruction's last cycle
// RQ4 - take: clear global enable, then clear latch, then call vector
// RQ5 - the call pushes program counter, carry and zero flags only
// RQ6 - return instruction pops pc and flags and re-enables interrupts
// RQ7 - enable instruction inside a service routine allows nesting
// RQ8 - after reset fetch starts at address zero; vectors are two bytes
// RQ9 - fixed vectors for bus reset, both ticks and three endpoints
// RQ10 - all current-sink pins share vector 0x14 with no pin priority
// RQ11 - all general pins share vector 0x16 with no pin priority
// RQ12 - latency is remaining cycles plus ten for call plus five jump
// RQ13 - bus reset request after single-ended zero longer than 8 us
// RQ14 - three endpoint sources gated by endpoint enable bits 0 to 2
// RQ15 - an endpoint requests after a packet is sent on the bus
// RQ16 - firmware should disable timer interrupts before suspend
// RQ17 - sink pins request on edge chosen by per-pin polarity
// RQ18 - a triggered sink pin blocks others until inactive or disabled
// RQ19 - acknowledge leaves the sink pin enable register unchanged
// RQ20 - each of 32 general pins requests with per-port polarity
// RQ21 - a triggered general pin blocks others until inactive or disabled
// RQ22 - acknowledge leaves the general port enable registers unchanged
// RQ23 - status bit 2 shows global enable, read-only
// RQ24 - status bit 7 shows a recognised request, cleared by acknowledge
// RQ25 - bus reset also sets status bit 5 without resetting the core
// RQ26 - of several pending requests the lowest vector number goes first
module mic_irq_ctrl #(
   parameter SINK_PINS = 8,
   parameter GPIO_PINS = 32,
   parameter GPIO_PORTS = 4,
   parameter SE0_CYCLES = (`MIC_SE0_TIME_NS / `MIC_CLK_PERIOD_NS) + 1
) (
   input wire core_clk_in,
   input wire sys_rst_in,
   // wishbone slave
   input wire wb_cyc_in,
   input wire wb_stb_in,
   input wire wb_we_in,
   input wire [9:0] wb_adr_in,
   input wire [3:0] wb_sel_in,
   input wire [31:0] wb_dat_in,
   output wire [31:0] wb_dat_out,
   output wire wb_ack_out,
   // processor core
   input wire instr_last_in,
   input wire enable_irq_instr_in,
   input wire disable_irq_instr_in,
   input wire irq_return_instr_in,
   output wire irq_call_out,
   output wire irq_push_flags_out,
   output wire [15:0] irq_vector_out,
   output wire irq_global_en_out,
   // sources
   input wire usb_dp_in,
   input wire usb_dm_in,
   input wire tick_128us_in,
   input wire tick_1024us_in,
   input wire [2:0] ep_packet_sent_in,
   input wire [SINK_PINS-1:0] sink_pin_in,
   input wire [SINK_PINS-1:0] sink_pin_en_in,
   input wire [SINK_PINS-1:0] sink_pin_pol_in,
   input wire [GPIO_PINS-1:0] gpio_pin_in,
   input wire [GPIO_PINS-1:0] gpio_pin_en_in,
   input wire [GPIO_PORTS-1:0] gpio_port_pol_in
);

   localparam ST_IDLE = 2'd0;
   localparam ST_CLEAR = 2'd1;
   localparam ST_CALL = 2'd2;
   localparam NSRC = 12;
   localparam PORT_W = GPIO_PINS / GPIO_PORTS;

   function [NSRC-1:0] lowest_one;
      input [NSRC-1:0] x;
      begin
         lowest_one = x & (~x + {{(NSRC-1){1'b0}}, 1'b1});
      end
   endfunction

   function [3:0] enc_num;
      input [NSRC-1:0] onehot;
      integer i;
      begin
         enc_num = 4'h0;
         for (i = 0; i < NSRC; i = i + 1) begin
            if (onehot[i]) begin
               enc_num = i[3:0];
            end
         end
      end
   endfunction

   // ---------------- pin synchronisers ----------------
   // a level is taken once the second and third stages agree
   // the old level holds while they differ, so glitches are dropped
   localparam SYW = 2 + SINK_PINS + GPIO_PINS;
   wire [SYW-1:0] raw_pins;
   reg [SYW-1:0] sy1_q, sy2_q, sy3_q, pins_q;
   assign raw_pins = {gpio_pin_in, sink_pin_in, usb_dm_in, usb_dp_in};

   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         sy1_q <= {SYW{1'b0}};
         sy2_q <= {SYW{1'b0}};
         sy3_q <= {SYW{1'b0}};
         pins_q <= {SYW{1'b0}};
      end else begin
         sy1_q <= raw_pins;
         sy2_q <= sy1_q;
         sy3_q <= sy2_q;
         pins_q <= (sy2_q & ~(sy2_q ^ sy3_q)) | (pins_q & (sy2_q ^ sy3_q));
      end
   end

   wire dp_s = pins_q[0];
   wire dm_s = pins_q[1];
   wire [SINK_PINS-1:0] sink_s = pins_q[2 +: SINK_PINS];
   wire [GPIO_PINS-1:0] gpio_s = pins_q[2 + SINK_PINS +: GPIO_PINS];

   // ---------------- enable registers ----------------
   // reserved bits are masked on write and read back as zero
   reg [7:0] gen_q, ep_en_q;
   reg gie_q;
   reg busrst_flag_q;
   reg pend_flag_q;
   reg [NSRC-1:0] latch_q;

   // ---------------- wishbone slave ----------------
   // ack blocks a second take of a strobe that is still held
   // read data is caught with the request and stands until the next
   reg ack_q;
   reg [31:0] rdat_q;
   wire req = wb_cyc_in & wb_stb_in & ~ack_q;
   wire [7:0] idx = wb_adr_in[9:2];
   wire wr = req & wb_we_in & wb_sel_in[0];
   wire wr_gen = wr & (idx == `MIC_IDX_GLOBAL_EN);
   wire wr_ep = wr & (idx == `MIC_IDX_EP_EN);
   wire wr_st = wr & (idx == `MIC_IDX_STATUS);
   reg [7:0] rd_mux;

   always @* begin
      case (idx)
         `MIC_IDX_GLOBAL_EN: rd_mux = gen_q;
         `MIC_IDX_EP_EN: rd_mux = ep_en_q;
         `MIC_IDX_STATUS: begin
            rd_mux = 8'h00;
            rd_mux[`MIC_ST_PEND] = pend_flag_q; // see RQ24
            rd_mux[`MIC_ST_BUSRST] = busrst_flag_q;
            rd_mux[`MIC_ST_GIE] = gie_q; // see RQ23
         end
         default: rd_mux = 8'h00;
      endcase
   end

   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0000_0000;
      end else begin
         ack_q <= req;
         if (req) begin
            rdat_q <= {24'h00_0000, rd_mux};
         end
      end
   end

   assign wb_ack_out = ack_q;
   assign wb_dat_out = rdat_q;

   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         gen_q <= `MIC_EN_RESET; // see RQ2
         ep_en_q <= `MIC_EN_RESET; // see RQ2
      end else begin
         if (wr_gen) begin
            gen_q <= wb_dat_in[7:0] & `MIC_GEN_WMASK;
         end
         if (wr_ep) begin
            ep_en_q <= wb_dat_in[7:0] & `MIC_EP_WMASK; // see RQ14
         end
      end
   end

   // ---------------- bus reset detector ----------------
   // the count saturates, so one long reset raises one request only
   reg [15:0] se0_cnt_q;
   wire se0 = ~dp_s & ~dm_s;
   wire se0_hit = se0 & (se0_cnt_q == SE0_CYCLES[15:0] - 16'h0001);

   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         se0_cnt_q <= 16'h0000;
      end else if (!se0) begin
         se0_cnt_q <= 16'h0000;
      end else if (se0_cnt_q != SE0_CYCLES[15:0]) begin
         se0_cnt_q <= se0_cnt_q + 16'h0001; // see RQ13
      end
   end

   // ---------------- current-sink pins ----------------
   // polarity folds into the active level; a one selects rising edges
   reg [SINK_PINS-1:0] sink_act_q, sink_lock_q;
   wire [SINK_PINS-1:0] sink_pol_fix = sink_pin_pol_in;
   wire [SINK_PINS-1:0] sink_act = ~(sink_s ^ sink_pol_fix);
   // enables are inputs only; acknowledge never writes them, see RQ19
   wire [SINK_PINS-1:0] sink_edge = sink_act & ~sink_act_q & sink_pin_en_in;
   // the lock lifts when its pin goes inactive or loses its enable
   wire sink_free = ~|(sink_lock_q & sink_act & sink_pin_en_in);
   wire [SINK_PINS-1:0] sink_pick = sink_edge & (~sink_edge + 1'b1);
   wire sink_trig = sink_free & (|sink_edge);

   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         sink_act_q <= {SINK_PINS{1'b0}};
         sink_lock_q <= {SINK_PINS{1'b0}};
      end else begin
         sink_act_q <= sink_act; // see RQ17
         if (sink_trig) begin
            sink_lock_q <= sink_pick; // see RQ18
         end else if (sink_free) begin
            sink_lock_q <= {SINK_PINS{1'b0}};
         end
      end
   end

   // ---------------- general-purpose pins ----------------
   // each pin takes the polarity of its port
   reg [GPIO_PINS-1:0] gpio_pol;
   integer p;
   always @* begin
      gpio_pol = {GPIO_PINS{1'b0}};
      for (p = 0; p < GPIO_PINS; p = p + 1) begin
         gpio_pol[p] = gpio_port_pol_in[p / PORT_W]; // see RQ20
      end
   end

   reg [GPIO_PINS-1:0] gpio_act_q, gpio_lock_q;
   wire [GPIO_PINS-1:0] gpio_act = ~(gpio_s ^ gpio_pol);
   // port enables are inputs only; acknowledge leaves them, see RQ22
   wire [GPIO_PINS-1:0] gpio_edge = gpio_act & ~gpio_act_q & gpio_pin_en_in;
   wire gpio_free = ~|(gpio_lock_q & gpio_act & gpio_pin_en_in);
   wire [GPIO_PINS-1:0] gpio_pick = gpio_edge & (~gpio_edge + 1'b1);
   wire gpio_trig = gpio_free & (|gpio_edge);

   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         gpio_act_q <= {GPIO_PINS{1'b0}};
         gpio_lock_q <= {GPIO_PINS{1'b0}};
      end else begin
         gpio_act_q <= gpio_act;
         if (gpio_trig) begin
            gpio_lock_q <= gpio_pick; // see RQ21
         end else if (gpio_free) begin
            gpio_lock_q <= {GPIO_PINS{1'b0}};
         end
      end
   end

   // ---------------- request latches ----------------
   // reserved vector slots have no source and stay clear
   reg [NSRC-1:0] set_vec;
   always @* begin
      set_vec = {NSRC{1'b0}};
      // enables gate each source before it latches, see RQ1
      set_vec[`MIC_VEC_BUSRST] = se0_hit & gen_q[`MIC_GEN_BUSRST];
      set_vec[`MIC_VEC_T128] = tick_128us_in & gen_q[`MIC_GEN_T128];
      set_vec[`MIC_VEC_T1024] = tick_1024us_in & gen_q[`MIC_GEN_T1024];
      set_vec[`MIC_VEC_EP0 +: 3] = ep_packet_sent_in & ep_en_q[2:0]; // see RQ15
      set_vec[`MIC_VEC_SINK] = sink_trig & gen_q[`MIC_GEN_SINK]; // see RQ10
      set_vec[`MIC_VEC_GPIO] = gpio_trig & gen_q[`MIC_GEN_GPIO]; // see RQ11
   end

   // ---------------- acknowledge sequencer ----------------
   // idle, clear the serviced latch, then ten call cycles
   // the vector stands until the next take for the core to fetch
   reg [1:0] state_q;
   reg [NSRC-1:0] serv_q;
   reg [3:0] call_cnt_q;
   reg [15:0] vector_q;
   // take only in an instruction's last cycle with the mask open
   wire [NSRC-1:0] pick = lowest_one(latch_q); // see RQ26
   wire take = (state_q == ST_IDLE) & instr_last_in & gie_q & (|latch_q);
   wire [NSRC-1:0] clr_vec = (state_q == ST_CLEAR) ? serv_q : {NSRC{1'b0}};

   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         latch_q <= {NSRC{1'b0}};
      end else begin
         // a set in the clearing cycle survives
         latch_q <= (latch_q & ~clr_vec) | set_vec; // see RQ4
      end
   end

   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         state_q <= ST_IDLE;
         serv_q <= {NSRC{1'b0}};
         call_cnt_q <= 4'h0;
         vector_q <= 16'h0000; // see RQ8
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (take) begin // see RQ3
                  serv_q <= pick;
                  vector_q <= {11'h000, enc_num(pick), 1'b0}; // see RQ9
                  state_q <= ST_CLEAR;
               end
            end
            ST_CLEAR: begin
               call_cnt_q <= `MIC_CALL_CYCLES - 4'h1;
               state_q <= ST_CALL;
            end
            ST_CALL: begin
               if (call_cnt_q == 4'h0) begin
                  state_q <= ST_IDLE;
               end else begin
                  call_cnt_q <= call_cnt_q - 4'h1; // see RQ12
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // global enable: take masks first, return and enable re-arm
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         gie_q <= 1'b0;
      end else if (take | disable_irq_instr_in) begin
         gie_q <= 1'b0; // see RQ4
      end else if (enable_irq_instr_in | irq_return_instr_in) begin
         gie_q <= 1'b1; // see RQ6 see RQ7
      end
   end

   // status flags; hardware set wins over clear
   always @(posedge core_clk_in) begin
      if (sys_rst_in) begin
         busrst_flag_q <= 1'b0;
         pend_flag_q <= 1'b0;
      end else begin
         if (se0_hit) begin
            busrst_flag_q <= 1'b1; // see RQ25
         end else if (wr_st) begin
            busrst_flag_q <= wb_dat_in[`MIC_ST_BUSRST];
         end
         if (|set_vec) begin
            pend_flag_q <= 1'b1; // see RQ24
         end else if (take) begin
            pend_flag_q <= 1'b0;
         end
      end
   end

   // the core pushes pc and flags while the call runs, see RQ5
   assign irq_call_out = (state_q == ST_CALL);
   assign irq_push_flags_out = (state_q == ST_CALL) & (call_cnt_q == 4'h0);
   assign irq_vector_out = vector_q;
   assign irq_global_en_out = gie_q;

endmodule // mic_irq_ctrl

`default_nettype wire

// file: tb/mic_irq_checker.sv
/* port assertions for mic_irq_ctrl.
   assumes it is bound to every instance of the controller. */
`default_nettype none
module mic_irq_checker (
   input wire logic core_clk_in,
   input wire logic sys_rst_in,
   input wire logic instr_last_in,
   input wire logic enable_irq_instr_in,
   input wire logic disable_irq_instr_in,
   input wire logic irq_return_instr_in,
   input wire logic irq_call_out,
   input wire logic irq_push_flags_out,
   input wire logic [15:0] irq_vector_out,
   input wire logic irq_global_en_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (sys_rst_in);
   a_take_seq: assert property ($rose(irq_call_out) |->
      !irq_global_en_out && $past(irq_global_en_out, 2) &&
      $past(instr_last_in, 2)) else $error("call without take");
   a_call_ten: assert property ($rose(irq_call_out) |->
      irq_call_out[*8] ##1 irq_call_out[*2] ##1 !irq_call_out)
      else $error("call length wrong");
   a_push_last: assert property ($rose(irq_call_out) |->
      !irq_push_flags_out[*8] ##1 !irq_push_flags_out ##1
      irq_push_flags_out) else $error("push not in last call cycle");
   a_vec_legal: assert property ($rose(irq_call_out) |->
      irq_vector_out inside {16'h0002, 16'h0004, 16'h0006, 16'h0008,
      16'h000a, 16'h000c, 16'h0014, 16'h0016}) else $error("bad vector");
   a_ret_gie: assert property (irq_return_instr_in &&
      !disable_irq_instr_in && !irq_call_out && !instr_last_in |=>
      irq_global_en_out) else $error("return left gie off");
   a_ei_gie: assert property (enable_irq_instr_in &&
      !disable_irq_instr_in && !irq_call_out && !instr_last_in |=>
      irq_global_en_out) else $error("enable ignored");
   a_di_gie: assert property (disable_irq_instr_in |=>
      !irq_global_en_out) else $error("disable ignored");
   a_gie_cause: assert property ($rose(irq_global_en_out) |->
      $past(enable_irq_instr_in || irq_return_instr_in))
      else $error("gie rose without instruction");
   cover property ($rose(irq_call_out));
   cover property (irq_push_flags_out && irq_vector_out == 16'h0002);
   cover property ($fell(irq_call_out) ##[1:30] enable_irq_instr_in);
endmodule // mic_irq_checker
bind mic_irq_ctrl mic_irq_checker chk (.core_clk_in, .sys_rst_in,
   .instr_last_in, .enable_irq_instr_in, .disable_irq_instr_in,
   .irq_return_instr_in, .irq_call_out, .irq_push_flags_out,
   .irq_vector_out, .irq_global_en_out);
`default_nettype wire

// file: tb/mic_cpu_model.sv
/* behavioural processor core facing mic_irq_ctrl.
   assumes the controller's call, push and vector timing. */
`default_nettype none
module mic_cpu_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic irq_call_in,
   input wire logic irq_push_in,
   input wire logic ret_in,
   input wire logic [15:0] vec_in,
   output wire logic instr_last_out,
   output logic [15:0] pc_out,
   output logic [3:0] depth_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0] cnt_q, len_q, jmp_q;
   // no instruction ends during the call or the vector jump
   assign instr_last_out = !irq_call_in && jmp_q == 3'h0 && cnt_q == len_q;
   always @(posedge clk_in) begin
      if (rst_in) begin
         pc_out <= 16'h0000;
         depth_out <= 4'h0;
         cnt_q <= 3'h0;
         len_q <= 3'h0;
         jmp_q <= 3'h0;
      end else if (irq_push_in) begin
         pc_out <= vec_in;
         depth_out <= depth_out + 4'h1;
         jmp_q <= 3'h5;
      end else if (jmp_q != 3'h0) begin
         jmp_q <= jmp_q - 3'h1;
      end else if (instr_last_out) begin
         pc_out <= pc_out + 16'h0002;
         cnt_q <= 3'h0;
         len_q <= (len_q == 3'h4) ? 3'h0 : len_q + 3'h1;
      end else if (!irq_call_in) begin
         cnt_q <= cnt_q + 3'h1;
      end
      if (ret_in && !rst_in && depth_out != 4'h0)
         depth_out <= depth_out - 4'h1;
   end
endmodule // mic_cpu_model
`default_nettype wire

// file: tb/testbench.sv
/* self-checking bench for mic_irq_ctrl.
   assumes the core model and checker compile first. */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, cyc, stb, we, ack, last, call, push, gie, dp, dm;
   logic [9:0] adr;
   logic [31:0] wdat, rdat, gp, gen;
   logic [15:0] vec, rd;
   logic [4:0] ev;
   logic [2:0] ins;
   logic [7:0] sink, sen, spol;
   logic [3:0] depth, gpol, sel;
   int seed, error_cnt, n_checks, i, p;
   mic_irq_ctrl #(.SE0_CYCLES(20)) dut (.core_clk_in(clk), .sys_rst_in(rst),
      .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .instr_last_in(last), .enable_irq_instr_in(ins[0]),
      .disable_irq_instr_in(ins[1]), .irq_return_instr_in(ins[2]),
      .irq_call_out(call), .irq_push_flags_out(push), .irq_vector_out(vec),
      .irq_global_en_out(gie), .usb_dp_in(dp), .usb_dm_in(dm),
      .tick_128us_in(ev[0]), .tick_1024us_in(ev[1]),
      .ep_packet_sent_in(ev[4:2]), .sink_pin_in(sink), .sink_pin_en_in(sen),
      .sink_pin_pol_in(spol), .gpio_pin_in(gp), .gpio_pin_en_in(gen),
      .gpio_port_pol_in(gpol));
   mic_cpu_model cpu (.clk_in(clk), .rst_in(rst), .irq_call_in(call),
      .irq_push_in(push), .ret_in(ins[2]), .vec_in(vec), .instr_last_out(last),
      .pc_out(), .depth_out(depth));
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   function automatic logic [15:0] vaddr(input int n);
      return 16'(2 * n);
   endfunction
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d,
      input logic [3:0] s = 4'hf);
      int k;
      k = 0;
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w;
      sel <= s;
      adr <= a;
      wdat <= {24'h0, d};
      do @(posedge clk); while (ack !== 1'b1 && k++ < 50);
      if (ack !== 1'b1) error_cnt++;
      rd = rdat[15:0];
      cyc <= 0;
      stb <= 0;
   endtask
   task automatic evp(input logic [4:0] m);
      @(posedge clk) ev <= m;
      @(posedge clk) ev <= 5'h0;
   endtask
   task automatic op(input logic [2:0] m);
      @(posedge clk) ins <= m;
      @(posedge clk) ins <= 3'h0;
   endtask
   task automatic serve(input logic [15:0] e, input logic r);
      int k;
      k = 0;
      do @(posedge clk); while (push !== 1'b1 && k++ < 300);
      if (push !== 1'b1) error_cnt++;
      chk("vector", vec, e);
      chk("gie in call", {15'h0, gie}, 16'h0);
      repeat (6) @(posedge clk);
      if (r) op(3'b100);
   endtask
   task automatic quiet(input int n);
      int k;
      k = 0;
      repeat (n) begin
         @(posedge clk);
         if (call !== 1'b0) k++;
      end
      chk("no call", 16'(k), 16'h0);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      error_cnt++;
      conclude();
   end
   initial begin
      {seed, error_cnt, n_checks} = {32'd47, 32'd0, 32'd0};
      {rst, cyc, stb, we, dp, dm, adr, wdat} = {6'b100001, 42'h0};
      {ev, ins, sink, sen, gp, gen} = 88'h0;
      {spol, gpol, sel} = 16'hffff;
      repeat (20) @(posedge clk);
      rst <= 0;
      repeat (5) @(posedge clk);
      wb(0, 10'h080, 0);
      chk("gen reset", rd, 16'h0);
      wb(0, 10'h084, 0);
      chk("ep reset", rd, 16'h0);
      chk("vector reset", vec, 16'h0);
      wb(1, 10'h080, 8'hff);
      wb(0, 10'h080, 0);
      chk("gen mask", rd, 16'h0037);
      wb(1, 10'h084, 8'hff);
      wb(0, 10'h084, 0);
      chk("ep mask", rd, 16'h0007);
      wb(1, 10'h084, 8'h00, 4'he);
      wb(0, 10'h084, 0);
      chk("sel refused", rd, 16'h0007);
      wb(0, 10'h100, 0);
      chk("unmapped", rd, 16'h0);
      op(3'b001);
      op(3'b010);
      @(posedge clk);
      chk("gie off", {15'h0, gie}, 16'h0);
      $display("done regs");
      evp(5'h1f);
      wb(0, 10'h3fc, 0);
      chk("status", rd & 16'h00a4, 16'h0080);
      op(3'b001);
      for (i = 2; i < 7; i++) serve(vaddr(i), 1);
      wb(0, 10'h3fc, 0);
      chk("status", rd & 16'h00a4, 16'h0004);
      wb(1, 10'h080, 8'h35);
      wb(1, 10'h084, 8'h05);
      evp(5'h09);
      quiet(60);
      wb(1, 10'h080, 8'h37);
      wb(1, 10'h084, 8'h07);
      repeat (6) begin
         p = $unsigned($random(seed)) % 5;
         evp(5'h01 << p);
         serve(vaddr(p + 2), 1);
      end
      evp(5'h01);
      serve(16'h0004, 0);
      evp(5'h02);
      op(3'b001);
      serve(16'h0006, 1);
      op(3'b100);
      @(posedge clk);
      chk("stack depth", {12'h0, depth}, 16'h0);
      $display("done priority");
      p = $unsigned($random(seed)) % 8;
      @(posedge clk) sen <= 8'hff;
      @(posedge clk) sink[p] <= 1;
      serve(16'h0014, 1);
      @(posedge clk) sink[(p + 1) % 8] <= 1;
      quiet(40);
      @(posedge clk) sink <= 8'h0;
      repeat (6) @(posedge clk);
      sink[(p + 2) % 8] <= 1;
      serve(16'h0014, 1);
      @(posedge clk) sen <= 8'h0;
      sink[p] <= 1;
      spol[p] <= 0;
      repeat (6) @(posedge clk);
      sen <= 8'hff;
      quiet(10);
      sink[p] <= 0;
      serve(16'h0014, 1);
      p = $unsigned($random(seed)) % 32;
      @(posedge clk) gen <= 32'hffffffff;
      @(posedge clk) gp[p] <= 1;
      serve(16'h0016, 1);
      @(posedge clk) gp[(p + 9) % 32] <= 1;
      quiet(40);
      @(posedge clk) gp <= 32'h0;
      repeat (6) @(posedge clk);
      gp[(p + 3) % 32] <= 1;
      serve(16'h0016, 1);
      @(posedge clk) gen <= 32'h0;
      gp <= 32'h0;
      gpol <= 4'h0;
      repeat (6) @(posedge clk);
      gen <= 32'hffffffff;
      gp[p] <= 1;
      quiet(10);
      gp[p] <= 0;
      serve(16'h0016, 1);
      $display("done pins");
      @(posedge clk) dm <= 0;
      repeat (15) @(posedge clk);
      dm <= 1;
      quiet(40);
      @(posedge clk) dm <= 0;
      serve(16'h0002, 1);
      dm <= 1;
      wb(0, 10'h3fc, 0);
      chk("bus reset flag", rd & 16'h0020, 16'h0020);
      $display("done bus reset");
      wb(1, 10'h080, 8'h31);
      evp(5'h03);
      quiet(30);
      @(posedge clk) rst <= 1;
      repeat (3) @(posedge clk);
      rst <= 0;
      wb(0, 10'h080, 0);
      chk("gen rerun", rd, 16'h0);
      chk("vector rerun", vec, 16'h0);
      $display("done rerun");
      conclude();
   end
endmodule // testbench
`default_nettype wire
